/* File: verilog/i2c_nvreg_slave.sv */
// Serial-bus slave giving byte access to volatile and non-volatile registers
//
// Summary of operation
// - Select bit 0 (default): accesses hit non-volatile, writes also land volatile.
// - Select bit 1: accesses hit volatile only, non-volatile untouched.
// - Every byte goes most significant bit first.
// - Sda changes only while scl low, except start and stop.
// - Watch lines for start; answer nothing until a start is seen.
// - Starts during power-up or a non-volatile write are ignored.
// - Stop after a read or volatile write returns to standby.
// - Stop after a non-volatile write starts the write cycle, then standby.
// - Sender releases sda after 8 bits; receiver pulls low on ninth clock.
// - Acknowledge valid identification, address and write data bytes.
// - Identification valid only with upper bits 0101000; low bit is direction.
// - Write is start, id write, address, data, stop; three acks.
// - During a non-volatile write ignore the bus and release sda.
// - Read: id write, address, repeated start, id read, data, stop.
// - Read data source follows the select bit at address 08h.
// - After power-up sda is not driven.
// - No ack for a non-volatile write attempted before storage completes.
// - Two general purpose bytes, volatile and non-volatile, no function.
// - Readable setpoint resistor error code, 15 ohms per step off 9k.
`timescale 1ns/1ps
`include "nvreg_params.svh"
module i2c_nvreg_slave #(
  parameter int NV_WRITE_CYCLES = `NV_WRITE_CYCLES,
  parameter int POWERUP_CYCLES  = `POWERUP_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // Serial bus, open drain
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // Trimmed setpoint resistor error code
  input  wire logic [7:0] setpoint_err_in,
  // Status
  output logic            busy_out,
  output logic            volatile_only_out
);

  nvreg_pkg::line_evt_t   evt;
  nvreg_pkg::seq_state_t  state_ff;
  logic [3:0]             bit_cnt_ff;
  logic [7:0]             shift_ff;
  logic [7:0]             tx_ff;
  logic [7:0]             addr_ff;
  logic                   dir_rd_ff;
  logic                   tx_load;
  logic [7:0]             tx_data;
  logic                   sda_oe_ff;
  logic                   sda_out_ff;
  logic                   busy_out_ff;
  logic                   sel_out_ff;
  logic                   byte_done;
  logic                   id_match;
  // Volatile and non-volatile copies
  logic [7:0]             vol_gp_ff [0:1];
  logic [7:0]             nv_gp_ff  [0:1];
  logic                   vol_sel_ff;
  logic                   nv_sel_ff;
  // Pending non-volatile write
  logic                   nv_pend_ff;
  logic [7:0]             pend_addr_ff;
  logic [7:0]             pend_data_ff;
  logic                   commit;
  logic                   nv_start;
  logic                   nv_busy;
  logic                   nv_done;
  logic                   pwr_busy;
  logic                   bus_blocked;

  // ----------------------------------------------------------------------
  // Line conditioning and timers
  // ----------------------------------------------------------------------
  i2c_line_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .evt_out    (evt)
  );

  // Runs from reset release; starts are ignored until it ends
  cycle_timer #(
    .CYCLES        (POWERUP_CYCLES),
    .BUSY_AT_RESET (1'b1)
  ) u_powerup (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .start_in   (1'b0),
    .busy_out   (pwr_busy),
    .done_out   ()
  );

  // Non-volatile write cycle, 10 ms, half the 20 ms master spacing
  cycle_timer #(
    .CYCLES        (NV_WRITE_CYCLES),
    .BUSY_AT_RESET (1'b0)
  ) u_nv_write (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .start_in   (nv_start),
    .busy_out   (nv_busy),
    .done_out   (nv_done)
  );

  // ----------------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------------
  // Source picked by the select bit; busy always live
  function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                          input logic       vol_only,
                                          input logic       busy,
                                          input logic [7:0] err);
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      `REG_GP_A:         val = vol_only ? vol_gp_ff[0] : nv_gp_ff[0];
      `REG_GP_B:         val = vol_only ? vol_gp_ff[1] : nv_gp_ff[1];
      `REG_SETPOINT_ERR: val = err;
      `REG_CTRL_STATUS: begin
        val[`CTRL_SEL_BIT]  = vol_only ? vol_sel_ff : nv_sel_ff;
        val[`CTRL_BUSY_BIT] = busy;
      end
      default:           val = 8'h00;
    endcase
    return val;
  endfunction

  assign tx_data     = read_reg(addr_ff, vol_sel_ff, nv_busy,
                                setpoint_err_in);
  assign byte_done   = evt.scl_fall && (bit_cnt_ff == `BITS_PER_BYTE);
  assign id_match    = (shift_ff[7:1] == `ID_CODE);
  assign bus_blocked = pwr_busy || nv_busy;
  assign tx_load     = (state_ff == nvreg_pkg::ST_ID_ACK) &&
                       evt.scl_fall && dir_rd_ff;
  assign commit      = (state_ff == nvreg_pkg::ST_DATA) && byte_done;
  assign nv_start    = (state_ff != nvreg_pkg::ST_NV_WRITE) &&
                       !bus_blocked && evt.stop && nv_pend_ff;

  // ----------------------------------------------------------------------
  // Protocol sequencer
  // ----------------------------------------------------------------------
  // Sampling on scl rise and acting on scl fall keeps sda changes
  // inside scl low; relies on scl low lasting many clock cycles
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff   <= nvreg_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      addr_ff    <= 8'h00;
      dir_rd_ff  <= 1'b0;
    end else if (state_ff == nvreg_pkg::ST_NV_WRITE) begin
      if (nv_done) begin
        state_ff <= nvreg_pkg::ST_IDLE;
      end
    end else if (evt.start && !bus_blocked) begin
      state_ff   <= nvreg_pkg::ST_ID;
      bit_cnt_ff <= 4'h0;
    end else if (evt.stop) begin
      state_ff <= nv_start ? nvreg_pkg::ST_NV_WRITE
                           : nvreg_pkg::ST_IDLE;
    end else begin
      if (evt.scl_rise) begin
        shift_ff   <= {shift_ff[6:0], evt.sda};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      case (state_ff)
        nvreg_pkg::ST_ID: begin
          if (byte_done) begin
            dir_rd_ff <= shift_ff[0];
            state_ff  <= id_match ? nvreg_pkg::ST_ID_ACK
                                  : nvreg_pkg::ST_WAIT;
          end
        end
        nvreg_pkg::ST_ID_ACK: begin
          if (evt.scl_fall) begin
            bit_cnt_ff <= 4'h0;
            state_ff   <= dir_rd_ff ? nvreg_pkg::ST_TX
                                    : nvreg_pkg::ST_ADDR;
          end
        end
        nvreg_pkg::ST_ADDR: begin
          if (byte_done) begin
            addr_ff  <= shift_ff;
            state_ff <= nvreg_pkg::ST_ADDR_ACK;
          end
        end
        nvreg_pkg::ST_ADDR_ACK: begin
          if (evt.scl_fall) begin
            bit_cnt_ff <= 4'h0;
            state_ff   <= nvreg_pkg::ST_DATA;
          end
        end
        nvreg_pkg::ST_DATA: begin
          if (byte_done) begin
            state_ff <= nvreg_pkg::ST_DATA_ACK;
          end
        end
        nvreg_pkg::ST_DATA_ACK: begin
          if (evt.scl_fall) begin
            state_ff <= nvreg_pkg::ST_WAIT;
          end
        end
        nvreg_pkg::ST_TX: begin
          if (byte_done) begin
            state_ff <= nvreg_pkg::ST_TX_ACK;
          end
        end
        nvreg_pkg::ST_TX_ACK: begin
          // Master answers the byte, then stops the read
          if (evt.scl_fall) begin
            state_ff <= nvreg_pkg::ST_WAIT;
          end
        end
        nvreg_pkg::ST_IDLE,
        nvreg_pkg::ST_WAIT: begin
          state_ff <= state_ff;
        end
        default: state_ff <= nvreg_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sda driver
  // ----------------------------------------------------------------------
  // Only ever pulls low; released at reset and through write cycles
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sda_oe_ff <= 1'b0;
      tx_ff     <= 8'h00;
    end else if (state_ff == nvreg_pkg::ST_NV_WRITE || bus_blocked) begin
      sda_oe_ff <= 1'b0;
    end else if (evt.start || evt.stop) begin
      sda_oe_ff <= 1'b0;
    end else if (evt.scl_fall) begin
      case (state_ff)
        nvreg_pkg::ST_ID:   sda_oe_ff <= byte_done && id_match;
        nvreg_pkg::ST_ADDR: sda_oe_ff <= byte_done;
        nvreg_pkg::ST_DATA: sda_oe_ff <= byte_done;
        nvreg_pkg::ST_ID_ACK: begin
          sda_oe_ff <= tx_load ? ~tx_data[7] : 1'b0;
          tx_ff     <= tx_data;
        end
        nvreg_pkg::ST_TX: begin
          // Shift out below the msb; release after the eighth bit
          sda_oe_ff <= byte_done ? 1'b0 : ~tx_ff[6];
          tx_ff     <= {tx_ff[6:0], 1'b0};
        end
        default: sda_oe_ff <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  // Volatile copies take the data at once; non-volatile waits for
  // the end of the write cycle, during which starts and reads are ignored
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vol_gp_ff[0] <= `NV_GP_RESET;
      vol_gp_ff[1] <= `NV_GP_RESET;
      nv_gp_ff[0]  <= `NV_GP_RESET;
      nv_gp_ff[1]  <= `NV_GP_RESET;
      vol_sel_ff   <= `NV_SEL_RESET;
      nv_sel_ff    <= `NV_SEL_RESET;
      nv_pend_ff   <= 1'b0;
      pend_addr_ff <= 8'h00;
      pend_data_ff <= 8'h00;
    end else begin
      if (commit) begin
        case (addr_ff)
          `REG_GP_A:        vol_gp_ff[0] <= shift_ff;
          `REG_GP_B:        vol_gp_ff[1] <= shift_ff;
          `REG_CTRL_STATUS: vol_sel_ff   <= shift_ff[`CTRL_SEL_BIT];
          default:          vol_sel_ff   <= vol_sel_ff;
        endcase
        // Select bit 0 also queues the byte for non-volatile storage
        if (!vol_sel_ff && addr_ff >= `REG_GP_A &&
            addr_ff != `REG_SETPOINT_ERR &&
            addr_ff <= `REG_CTRL_STATUS) begin
          nv_pend_ff   <= 1'b1;
          pend_addr_ff <= addr_ff;
          pend_data_ff <= shift_ff;
        end
      end else if (evt.start && !bus_blocked) begin
        nv_pend_ff <= 1'b0;                          // Aborted write
      end
      if (nv_start) begin
        nv_pend_ff <= 1'b0;
      end
      if (nv_done) begin
        case (pend_addr_ff)
          `REG_GP_A:        nv_gp_ff[0] <= pend_data_ff;
          `REG_GP_B:        nv_gp_ff[1] <= pend_data_ff;
          `REG_CTRL_STATUS: nv_sel_ff <= pend_data_ff[`CTRL_SEL_BIT];
          default:          nv_sel_ff <= nv_sel_ff;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sda_out_ff  <= 1'b0;
      busy_out_ff <= 1'b0;
      sel_out_ff  <= `NV_SEL_RESET;
    end else begin
      sda_out_ff  <= 1'b0;
      busy_out_ff <= nv_busy;
      sel_out_ff  <= vol_sel_ff;
    end
  end

  assign sda_out           = sda_out_ff;
  assign sda_oe_out        = sda_oe_ff;
  assign busy_out          = busy_out_ff;
  assign volatile_only_out = sel_out_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_stop_nv;
    nv_start;
  endsequence

  sequence s_write_cycle;
    nv_busy [*8];
  endsequence

  a_busy_no_drive: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    nv_busy |=> !sda_oe_ff) else $error("sda driven in write cycle");

  a_start_ignored: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (evt.start && bus_blocked && state_ff == nvreg_pkg::ST_IDLE)
    |=> state_ff == nvreg_pkg::ST_IDLE) else $error("blocked start taken");

  a_stop_nv_cycle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_stop_nv |=> s_write_cycle ##0 state_ff == nvreg_pkg::ST_NV_WRITE)
    else $error("stop did not start write cycle");

  a_stop_standby: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (evt.stop && !nv_pend_ff && !bus_blocked)
    |=> state_ff == nvreg_pkg::ST_IDLE) else $error("stop left active");

  a_id_ack: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == nvreg_pkg::ST_ID && byte_done && !bus_blocked)
    |=> sda_oe_ff == $past(id_match)) else $error("wrong id answer");

  a_ack_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == nvreg_pkg::ST_DATA_ACK && evt.scl_fall)
    |=> !sda_oe_ff) else $error("ack not released");

  a_msb_first: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (tx_load && !bus_blocked && !evt.start && !evt.stop)
    |=> sda_oe_ff == !tx_ff[7]) else $error("msb not first");

  a_vol_only: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (commit && vol_sel_ff) |=> !nv_pend_ff) else $error("nv queued");

  a_idle_waits: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_ff == nvreg_pkg::ST_IDLE && !evt.start)
    |=> state_ff == nvreg_pkg::ST_IDLE) else $error("left idle");

  // Counts busy cycles; a stuck timer would carry it past the cycle length
  localparam logic [19:0] NV_LIMIT = NV_WRITE_CYCLES[19:0];
  logic [19:0]            busy_len_ff;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_len_ff <= 20'h0_0000;
    end else if (nv_busy) begin
      busy_len_ff <= busy_len_ff + 20'h0_0001;
    end else begin
      busy_len_ff <= 20'h0_0000;
    end
  end

  a_busy_bounded: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    busy_len_ff <= NV_LIMIT) else $error("busy stuck");

  a_no_ack_busy: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (nv_busy && evt.scl_fall) |=> !sda_oe_ff) else $error("ack in cycle");

endmodule

/* File: verilog/nvreg_params.svh */
// Constants for the serial register-access slave: offsets, fields, timing
`ifndef NVREG_PARAMS_SVH
`define NVREG_PARAMS_SVH

// Register offsets
`define REG_GP_A            8'h05
`define REG_GP_B            8'h06
`define REG_SETPOINT_ERR    8'h07
`define REG_CTRL_STATUS     8'h08

// Control/status field positions
`define CTRL_SEL_BIT        7
`define CTRL_BUSY_BIT       0

// Identification code in the seven upper bits of the first byte
`define ID_CODE             7'h28

// Reset contents of the non-volatile copies
`define NV_GP_RESET         8'h00
`define NV_SEL_RESET        1'b0

// Bits per byte on the serial bus
`define BITS_PER_BYTE       4'h8

// Timing: clock rate, times in microseconds, counts derived
`define CLK_FREQ_MHZ        10
`define NV_SPACING_TIME_US  20000
`define NV_WRITE_TIME_US    10000
`define POWERUP_TIME_US     1000
`define NV_WRITE_CYCLES     (`NV_WRITE_TIME_US * `CLK_FREQ_MHZ)
`define POWERUP_CYCLES      (`POWERUP_TIME_US * `CLK_FREQ_MHZ)

`endif

/* File: verilog/nvreg_pkg.sv */
// Types shared by the serial register-access slave
package nvreg_pkg;

  // Protocol sequencer states
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ID       = 4'h1,
    ST_ID_ACK   = 4'h2,
    ST_ADDR     = 4'h3,
    ST_ADDR_ACK = 4'h4,
    ST_DATA     = 4'h5,
    ST_DATA_ACK = 4'h6,
    ST_TX       = 4'h7,
    ST_TX_ACK   = 4'h8,
    ST_WAIT     = 4'h9,
    ST_NV_WRITE = 4'ha
  } seq_state_t;

  // Bus line events, each a one-cycle pulse except the sda level
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } line_evt_t;

endpackage

/* File: verilog/i2c_line_sync.sv */
// Two-flop synchronisers on the bus lines with edge, start and stop events
`timescale 1ns/1ps
module i2c_line_sync (
  // Clock and reset
  input  wire logic                sys_clk_in,
  input  wire logic                rst_in,
  // Raw bus lines
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  // Synchronised events
  output nvreg_pkg::line_evt_t     evt_out
);

  logic [1:0] scl_meta_ff;
  logic [1:0] sda_meta_ff;
  logic       scl_prev_ff;
  logic       sda_prev_ff;
  nvreg_pkg::line_evt_t nxt_evt;

  // First stage is read only by the second; idle bus reads high
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_meta_ff <= 2'h3;
      sda_meta_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_meta_ff <= {scl_meta_ff[0], scl_in};
      sda_meta_ff <= {sda_meta_ff[0], sda_in};
      scl_prev_ff <= scl_meta_ff[1];
      sda_prev_ff <= sda_meta_ff[1];
    end
  end

  // Start and stop need scl high on both samples around the sda edge
  always_comb begin
    nxt_evt.scl_rise = scl_meta_ff[1] & ~scl_prev_ff;
    nxt_evt.scl_fall = ~scl_meta_ff[1] & scl_prev_ff;
    nxt_evt.start    = scl_meta_ff[1] & scl_prev_ff &
                       sda_prev_ff & ~sda_meta_ff[1];
    nxt_evt.stop     = scl_meta_ff[1] & scl_prev_ff &
                       ~sda_prev_ff & sda_meta_ff[1];
    nxt_evt.sda      = sda_meta_ff[1];
  end

  assign evt_out = nxt_evt;

endmodule

/* File: verilog/cycle_timer.sv */
// Down-counter that holds busy for a fixed number of clock cycles
`timescale 1ns/1ps
module cycle_timer #(
  parameter int CYCLES        = 100000,
  parameter bit BUSY_AT_RESET = 1'b0
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // Control
  input  wire logic start_in,
  // Status
  output logic      busy_out,
  output logic      done_out
);

  logic [19:0] count_ff;
  logic        busy_ff;
  logic        done_ff;

  // Count down; a start while busy is ignored so a cycle is never cut short
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_ff <= BUSY_AT_RESET ? CYCLES[19:0] : 20'h0_0000;
      busy_ff  <= BUSY_AT_RESET;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (busy_ff) begin
        if (count_ff <= 20'h0_0001) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          count_ff <= 20'h0_0000;
        end else begin
          count_ff <= count_ff - 20'h0_0001;
        end
      end else if (start_in) begin
        busy_ff  <= 1'b1;
        count_ff <= CYCLES[19:0];
      end
    end
  end

  assign busy_out = busy_ff;
  assign done_out = done_ff;

endmodule

/* File: bench/i2c_master_model.sv */
// Serial bus master model that drives the slave's bus lines
`timescale 1ns/1ps
module i2c_master_model (
  // Clock
  input  wire logic sys_clk_in,
  // Resolved data line
  input  wire logic sda_in,
  // Bus drive, a released line is pulled high
  output logic      scl_out,
  output logic      sda_rel_out
);
  // Idle bus: clock stands high, data released
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start_cond();
    hold(4);
    sda_rel_out <= 1'b1;
    hold(5);
    scl_out <= 1'b1;
    hold(10);
    sda_rel_out <= 1'b0;
    hold(10);
    scl_out <= 1'b0;
  endtask

  // Stop: data rises with the clock high, then the clock stands still
  task automatic stop_cond();
    hold(4);
    sda_rel_out <= 1'b0;
    hold(5);
    scl_out <= 1'b1;
    hold(10);
    sda_rel_out <= 1'b1;
    hold(10);
  endtask

  // One bit: data moves mid-low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    hold(4);
    sda_rel_out <= b;
    hold(5);
    scl_out <= 1'b1;
    hold(9);
    @(negedge sys_clk_in);
    r = sda_in;
    @(posedge sys_clk_in);
    scl_out <= 1'b0;
  endtask

  // Byte msb first, ninth clock carries the acknowledge
  task automatic byte_io(input logic [7:0] d, input logic ak,
                         output logic [7:0] q, output logic akr);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ak, akr);
  endtask
endmodule

/* File: bench/i2c_nvreg_slave_tb.sv */
// Self-checking bench for the serial register-access slave
`timescale 1ns/1ps
`include "nvreg_params.svh"
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module i2c_nvreg_slave_tb;
  // Short write cycle and power-up keep the run brief
  localparam int NVW = 800;
  localparam logic [7:0] ID_WR = {`ID_CODE, 1'b0};
  localparam logic [7:0] ID_RD = {`ID_CODE, 1'b1};
  logic       sys_clk_in = 1'b0;
  logic       rst_in;
  logic       scl;
  logic       sda_rel;
  logic       sda_out;
  logic       sda_oe_out;
  logic [7:0] err_code;
  logic       busy_out;
  logic       vol_only;
  logic [2:0] ak;
  logic [7:0] q;
  int         num_errors = 0;
  int         checks_done = 0;
  int         cycles = 0;
  int         oe_busy = 0;
  // Pull-up wire: low when either party pulls it
  wire        sda = sda_rel & (sda_oe_out ? sda_out : 1'b1);

  i2c_nvreg_slave #(
    .NV_WRITE_CYCLES (NVW),
    .POWERUP_CYCLES  (60)
  ) uut (
    .sys_clk_in        (sys_clk_in),
    .rst_in            (rst_in),
    .scl_in            (scl),
    .sda_in            (sda),
    .sda_out           (sda_out),
    .sda_oe_out        (sda_oe_out),
    .setpoint_err_in   (err_code),
    .busy_out          (busy_out),
    .volatile_only_out (vol_only)
  );
  i2c_master_model m (
    .sys_clk_in  (sys_clk_in),
    .sda_in      (sda),
    .scl_out     (scl),
    .sda_rel_out (sda_rel)
  );

  always #50 sys_clk_in = ~sys_clk_in;

  // Watchdog; also counts any drive of the line during a write cycle
  always @(posedge sys_clk_in) begin
    cycles++;
    if (busy_out === 1'b1 && sda_oe_out !== 1'b0) oe_busy++;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // Transfer tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, d, output logic [2:0] k);
    logic [7:0] x;
    m.start_cond();
    m.byte_io(ID_WR, 1'b1, x, k[2]);
    m.byte_io(a, 1'b1, x, k[1]);
    m.byte_io(d, 1'b1, x, k[0]);
    m.stop_cond();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic [2:0] k);
    logic [7:0] x;
    m.start_cond();
    m.byte_io(ID_WR, 1'b1, x, k[2]);
    m.byte_io(a, 1'b1, x, k[1]);
    m.start_cond();
    m.byte_io(ID_RD, 1'b1, x, k[0]);
    m.byte_io(8'hff, 1'b0, d, x[0]);
    m.stop_cond();
  endtask

  // Check busy after a stop; a stored write must end in bounded time
  task automatic busy_chk(input logic exp);
    int n;
    n = 0;
    repeat (2) @(negedge sys_clk_in);
    `CHK(busy_out, exp)
    while (busy_out !== 1'b0 && n < NVW + 50) begin
      @(negedge sys_clk_in);
      n++;
    end
    `CHK(busy_out, 1'b0)
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    rst_in = 1'b1;
    err_code = 8'ha5;
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(negedge sys_clk_in);
    `CHK({sda_oe_out, busy_out, vol_only}, 3'b000)
    wr(`REG_GP_A, 8'h11, ak);
    `CHK(ak, 3'b111)
    tend("powerup");
    for (int i = 1; i < 8; i++) begin
      m.start_cond();
      m.byte_io(ID_WR ^ (8'h01 << i), 1'b1, q, ak[0]);
      m.stop_cond();
      `CHK(ak[0], 1'b1)
    end
    tend("bad_id");
    rd(`REG_SETPOINT_ERR, q, ak);
    `CHK({ak, q}, {3'b000, 8'ha5})
    rd(8'h10, q, ak);
    `CHK({ak, q}, {3'b000, 8'h00})
    tend("read");
    wr(`REG_GP_A, 8'h3c, ak);
    `CHK(ak, 3'b000)
    wr(`REG_GP_B, 8'h77, ak);
    `CHK(ak, 3'b111)
    busy_chk(1'b1);
    `CHK(oe_busy, 0)
    rd(`REG_GP_A, q, ak);
    `CHK({ak, q}, {3'b000, 8'h3c})
    rd(`REG_CTRL_STATUS, q, ak);
    `CHK(q, 8'h00)
    tend("nv_write");
    wr(`REG_CTRL_STATUS, 8'h80, ak);
    `CHK(ak, 3'b000)
    busy_chk(1'b1);
    `CHK(vol_only, 1'b1)
    wr(`REG_GP_B, 8'h5a, ak);
    busy_chk(1'b0);
    rd(`REG_GP_B, q, ak);
    `CHK({ak, q}, {3'b000, 8'h5a})
    wr(`REG_CTRL_STATUS, 8'h00, ak);
    busy_chk(1'b0);
    `CHK(vol_only, 1'b0)
    rd(`REG_GP_B, q, ak);
    `CHK(q, `NV_GP_RESET)
    tend("volatile");
    test_done();
  end
endmodule
